// ==== strip_map.svh ====
// Constants for the channel strip control block: field positions, defaults, timing.
// Assumes a 40 MHz ref_clk; timing figures are kept in their own unit and derived.
`ifndef STRIP_MAP_SVH
`define STRIP_MAP_SVH
// ==========================================
// Clock and timing
`define CLK_HZ 40000000
`define GAIN_IDLE_S 5
`define HOLD_S 2
`define LISTEN_S 10
`define GAIN_IDLE_CYC (`CLK_HZ * `GAIN_IDLE_S)
`define HOLD_CYC (`CLK_HZ * `HOLD_S)
`define LISTEN_CYC (`CLK_HZ * `LISTEN_S)
`define DTAP_CYC (`CLK_HZ / 4)
`define SHOW_CYC (`CLK_HZ / 2)
`define SLOW_FLASH_CYC (`CLK_HZ)
`define FAST_FLASH_CYC (`CLK_HZ / 2)
`define SLOW_BLINK_BIT 24
`define FAST_BLINK_BIT 21
// ==========================================
// Levels: 0..8 knob position, LED count = position+1
`define LEVEL_MAX 4'h8
`define LEVEL_DEFAULT 4'h5
`define LEVEL_UNITY 4'h4
`define NUM_CH 6
`define AUTO_CH_LAST 3'h5
`endif

// ==== strip_pkg.sv ====
// Types for the channel strip control block.
// Assumes strip_map.svh constants are used for all figures.
package strip_pkg;
	// ==========================================
	// Per-channel stored settings
	typedef struct packed {
		logic [3:0] volume;
		logic [3:0] gain;
		logic mute;
		logic auto_set;
		logic [7:0] eq_comp_fx;
	} chan_set_t;
	// Knob controller modes
	typedef enum logic [2:0] {
		MODE_VOL = 3'b000,
		MODE_GAIN = 3'b001,
		MODE_LISTEN = 3'b010,
		MODE_SHOW = 3'b011,
		MODE_SLOW = 3'b100,
		MODE_FAST = 3'b101
	} knob_mode_t;
	// Ring LED colour drive
	typedef struct packed {
		logic [8:0] green;
		logic [8:0] white;
		logic red9;
	} ring_t;
endpackage : strip_pkg

// ==== chan_store.sv ====
// Small settings memory: one chan_set_t word per channel, registered read.
// Assumes write and read addresses are in range.
`timescale 1ns/1ps
`include "strip_map.svh"
module chan_store #(
	parameter int DEPTH = `NUM_CH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire strip_pkg::chan_set_t wr_data,
	// Read port
	input wire logic [2:0] rd_addr,
	output strip_pkg::chan_set_t rd_data
);
	import strip_pkg::*;
	chan_set_t mem [DEPTH]; // One word per channel
	// ==========================================
	// Storage with defaults after reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '{volume: `LEVEL_DEFAULT, gain: `LEVEL_DEFAULT, mute: 1'b0,
					auto_set: 1'b0, eq_comp_fx: 8'h00};
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end
	// Registered read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : chan_store

// ==== strip_ctrl.sv ====
// Channel strip UI control: channel select, level knob modes, mute, auto-gain, LED ring.
// Assumes button/knob inputs are debounced single pulses from the same clock domain
// except the raw knob press level and clip pin, which are synchronised here.
// Behaviour
// - Exactly one channel selected, lit green.
// - Selecting a channel recalls its stored settings.
// - Knob defaults volume; tap enters gain mode.
// - Gain mode times out after five idle seconds.
// - Gain default is six ring LEDs.
// - Gain mode ninth LED white max, red clip.
// - Double tap mutes; any tap unmutes.
// - Two second hold enters auto-gain listening.
// - Listening: gain indicator solid, ring slow-flashes white.
// - Listening lasts ten seconds, then gain fixed.
// - Ring shows auto-gain position in real time.
// - Rotation ignored during listening.
// - Completion shows position, flashes slow, fast, returns.
// - Manual gain change discards auto-gain result.
// - New hold restarts auto-gain, overwriting result.
// - Auto-gain only on inputs one to six.
// - Volume off to max; unity is five LEDs.
// - Volume default is six ring LEDs.
// - Volume mode ninth LED green max, red clip.
`timescale 1ns/1ps
`include "strip_map.svh"
module strip_ctrl #(
	parameter int GAIN_IDLE_CYC = `GAIN_IDLE_CYC,
	parameter int HOLD_CYC = `HOLD_CYC,
	parameter int LISTEN_CYC = `LISTEN_CYC,
	parameter int DTAP_CYC = `DTAP_CYC,
	parameter int SHOW_CYC = `SHOW_CYC,
	parameter int SLOW_FLASH_CYC = `SLOW_FLASH_CYC,
	parameter int FAST_FLASH_CYC = `FAST_FLASH_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Channel buttons, one-cycle pulses
	input wire logic [`NUM_CH-1:0] chan_btn,
	// Level knob: raw press level, rotation pulses
	input wire logic knob_press,
	input wire logic knob_cw,
	input wire logic knob_ccw,
	// Other stored parameters of the selected channel, edited elsewhere
	input wire logic [7:0] edit_params,
	input wire logic edit_params_wr,
	// Auto-gain engine proposal and raw clip pin
	input wire logic [3:0] auto_gain_level,
	input wire logic clip_pin,
	// Panel outputs
	output logic [`NUM_CH-1:0] chan_led,
	output strip_pkg::ring_t ring,
	output logic gain_led_white,
	output logic vol_led_green,
	output logic vol_led_red,
	output logic overload_indicator,
	// Active values of the selected channel
	output strip_pkg::chan_set_t active,
	output logic listening
);
	import strip_pkg::*;
	// ==========================================
	// Synchronisers for asynchronous pins
	logic [1:0] press_sync; // Press level, two stages
	logic [1:0] clip_sync; // Clip level, two stages
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			press_sync <= 2'b00;
			clip_sync <= 2'b00;
		end else begin
			press_sync <= {press_sync[0], knob_press};
			clip_sync <= {clip_sync[0], clip_pin};
		end
	end
	logic pressed; // Stage-two press
	logic clipping; // Stage-two clip
	assign pressed = press_sync[1];
	assign clipping = clip_sync[1];
	// ==========================================
	// Press classification: tap, double tap, hold
	logic pressed_d; // Previous press level
	logic [31:0] hold_cnt; // Cycles held
	logic hold_fired; // Hold already acted on
	logic tap_pend; // First tap awaiting partner
	logic [31:0] dtap_cnt; // Double-tap window
	logic single_tap; // One-cycle pulses
	logic double_tap;
	logic hold_evt;
	logic release_evt;
	assign release_evt = pressed_d && !pressed;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pressed_d <= 1'b0;
			hold_cnt <= '0;
			hold_fired <= 1'b0;
		end else begin
			pressed_d <= pressed;
			// Count only while held; a hold acts once per press
			if (!pressed) begin
				hold_cnt <= '0;
				hold_fired <= 1'b0;
			end else if (hold_cnt == 32'(HOLD_CYC - 1)) begin
				hold_fired <= 1'b1;
				hold_cnt <= hold_cnt;
			end else if (!hold_fired) begin
				hold_cnt <= hold_cnt + 32'h1;
			end
		end
	end
	assign hold_evt = pressed && !hold_fired && (hold_cnt == 32'(HOLD_CYC - 1));
	// Tap pairing; a tap is a release that did not become a hold
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_pend <= 1'b0;
			dtap_cnt <= '0;
		end else if (release_evt && !hold_fired) begin
			tap_pend <= !tap_pend;
			dtap_cnt <= '0;
		end else if (tap_pend) begin
			dtap_cnt <= dtap_cnt + 32'h1;
			if (dtap_cnt == 32'(DTAP_CYC - 1)) begin
				tap_pend <= 1'b0;
			end
		end
	end
	assign double_tap = release_evt && !hold_fired && tap_pend;
	// Single tap is declared when the window lapses unpartnered
	assign single_tap = tap_pend && (dtap_cnt == 32'(DTAP_CYC - 1)) && !(release_evt && !hold_fired);
	// ==========================================
	// Channel selection and recall
	logic [2:0] sel; // Selected channel index
	logic [2:0] btn_idx; // Decoded button
	logic btn_any;
	logic recall_pend; // Store read in flight
	chan_set_t rd_word; // Store read data
	logic store_wr; // Write-back of active values
	knob_mode_t mode; // Knob controller state, read by the selection lockout
	knob_mode_t next_mode;
	always_comb begin
		btn_idx = 3'h0;
		btn_any = 1'b0;
		// Lowest pressed button wins when several arrive together
		for (int i = `NUM_CH - 1; i >= 0; i--) begin
			if (chan_btn[i]) begin
				btn_idx = 3'(i);
				btn_any = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel <= 3'h0;
			recall_pend <= 1'b0;
		end else begin
			recall_pend <= btn_any && (mode != MODE_LISTEN);
			// Switching is locked out while listening so the result lands on its channel
			if (btn_any && (mode != MODE_LISTEN)) begin
				sel <= btn_idx;
			end
		end
	end
	// One-hot indicator, from a register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_led <= '0;
		end else begin
			for (int i = 0; i < `NUM_CH; i++) begin
				chan_led[i] <= (sel == 3'(i));
			end
		end
	end
	// Active values write back every cycle except on a channel switch and the recall cycle after it
	assign store_wr = !recall_pend && !(btn_any && (mode != MODE_LISTEN));
	chan_store #(
		.DEPTH(`NUM_CH)
	) i_chan_store (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(store_wr),
		.wr_addr(sel),
		.wr_data(active),
		.rd_addr(btn_any ? btn_idx : sel),
		.rd_data(rd_word)
	);
	// ==========================================
	// Mode machine
	logic [31:0] mode_cnt; // Idle, listen and flash timing
	logic rotate;
	assign rotate = knob_cw || knob_ccw;
	assign listening = (mode == MODE_LISTEN);
	always_comb begin
		next_mode = mode;
		case (mode)
			MODE_VOL: begin
				if (hold_evt && sel <= `AUTO_CH_LAST) begin
					next_mode = MODE_LISTEN;
				end else if (single_tap && !active.mute) begin
					next_mode = MODE_GAIN;
				end
			end
			MODE_GAIN: begin
				if (hold_evt && sel <= `AUTO_CH_LAST) begin
					next_mode = MODE_LISTEN;
				end else if (single_tap && !active.mute) begin
					next_mode = MODE_VOL;
				end else if (!rotate && mode_cnt == 32'(GAIN_IDLE_CYC - 1)) begin
					next_mode = MODE_VOL;
				end
			end
			MODE_LISTEN: begin
				if (hold_evt) begin
					next_mode = MODE_LISTEN;
				end else if (mode_cnt == 32'(LISTEN_CYC - 1)) begin
					next_mode = MODE_SHOW;
				end
			end
			MODE_SHOW: begin
				if (mode_cnt == 32'(SHOW_CYC - 1)) begin
					next_mode = MODE_SLOW;
				end
			end
			MODE_SLOW: begin
				if (mode_cnt == 32'(SLOW_FLASH_CYC - 1)) begin
					next_mode = MODE_FAST;
				end
			end
			MODE_FAST: begin
				if (mode_cnt == 32'(FAST_FLASH_CYC - 1)) begin
					next_mode = MODE_VOL;
				end
			end
			default: begin
				next_mode = MODE_VOL;
			end
		endcase
		// Channel change drops back to volume view
		if (btn_any && mode != MODE_LISTEN) begin
			next_mode = MODE_VOL;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= MODE_VOL;
		end else begin
			mode <= next_mode;
		end
	end
	// Shared timer: restarts on entry, and on knob activity in gain mode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_cnt <= '0;
		end else if (next_mode != mode || hold_evt) begin
			mode_cnt <= '0;
		end else if (mode == MODE_GAIN && (rotate || release_evt || pressed)) begin
			mode_cnt <= '0;
		end else begin
			mode_cnt <= mode_cnt + 32'h1;
		end
	end
	// ==========================================
	// Active values: recall, knob edits, mute, auto-gain
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			active <= '{volume: `LEVEL_DEFAULT, gain: `LEVEL_DEFAULT, mute: 1'b0,
				auto_set: 1'b0, eq_comp_fx: 8'h00};
		end else if (recall_pend) begin
			active <= rd_word;
		end else begin
			if (edit_params_wr) begin
				active.eq_comp_fx <= edit_params;
			end
			// Mute toggles: double tap mutes, any tap unmutes
			if (active.mute && (single_tap || double_tap)) begin
				active.mute <= 1'b0;
			end else if (double_tap && (mode == MODE_VOL || mode == MODE_GAIN)) begin
				active.mute <= 1'b1;
			end
			if (mode == MODE_LISTEN) begin
				active.gain <= (auto_gain_level > `LEVEL_MAX) ? `LEVEL_MAX : auto_gain_level;
				active.auto_set <= 1'b1;
			end else if (mode == MODE_GAIN && rotate) begin
				active.auto_set <= 1'b0;
				if (knob_cw && active.gain < `LEVEL_MAX) begin
					active.gain <= active.gain + 4'h1;
				end else if (knob_ccw && active.gain != 4'h0) begin
					active.gain <= active.gain - 4'h1;
				end
			end else if (mode == MODE_VOL && rotate) begin
				// Position 0 is off, position 8 is the top of the range
				if (knob_cw && active.volume < `LEVEL_MAX) begin
					active.volume <= active.volume + 4'h1;
				end else if (knob_ccw && active.volume != 4'h0) begin
					active.volume <= active.volume - 4'h1;
				end
			end
		end
	end
	// ==========================================
	// Blink sources
	logic [`SLOW_BLINK_BIT:0] blink_cnt; // Free-running phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt <= '0;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end
	logic slow_on;
	logic fast_on;
	assign slow_on = !blink_cnt[`SLOW_BLINK_BIT];
	assign fast_on = !blink_cnt[`FAST_BLINK_BIT];
	// Bar decode used for both colours
	function automatic logic [8:0] bar(input logic [3:0] pos);
		logic [8:0] b;
		b = '0;
		for (int i = 0; i < 9; i++) begin
			b[i] = (4'(i) <= pos);
		end
		return b;
	endfunction : bar
	// ==========================================
	// LED drive, registered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ring <= '0;
			gain_led_white <= 1'b0;
			vol_led_green <= 1'b0;
			vol_led_red <= 1'b0;
			overload_indicator <= 1'b0;
		end else begin
			ring <= '0;
			gain_led_white <= (mode != MODE_VOL);
			vol_led_green <= (mode == MODE_VOL) && !active.mute;
			vol_led_red <= active.mute;
			overload_indicator <= clipping;
			case (mode)
				MODE_VOL: begin
					if (!active.mute || slow_on) begin
						ring.green <= bar(active.volume);
					end
					ring.red9 <= clipping;
					if (clipping) begin
						ring.green[8] <= 1'b0;
					end
				end
				MODE_GAIN: begin
					if (!active.mute || slow_on) begin
						ring.white <= bar(active.gain);
					end
					ring.red9 <= clipping;
					if (clipping) begin
						ring.white[8] <= 1'b0;
					end
				end
				MODE_LISTEN: begin
					if (slow_on) begin
						ring.white <= bar(active.gain);
					end
				end
				MODE_SHOW: begin
					ring.white <= bar(active.gain);
				end
				MODE_SLOW: begin
					ring.white <= slow_on ? 9'h1ff : 9'h000;
				end
				MODE_FAST: begin
					ring.white <= fast_on ? 9'h1ff : 9'h000;
				end
				default: begin
					ring <= '0;
				end
			endcase
		end
	end
endmodule : strip_ctrl

// ==== strip_ctrl_chk.sv ====
// ==========================================
// Port-level checker for strip_ctrl.
// Assumes it is bound to strip_ctrl; parameters follow the instance.
`timescale 1ns/1ps
`include "strip_map.svh"
module strip_ctrl_chk #(
	parameter int LISTEN_CYC = `LISTEN_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Operator inputs
	input wire logic [`NUM_CH-1:0] chan_btn,
	input wire logic knob_press,
	input wire logic knob_cw,
	input wire logic knob_ccw,
	input wire logic [3:0] auto_gain_level,
	input wire logic clip_pin,
	// Panel outputs
	input wire logic [`NUM_CH-1:0] chan_led,
	input wire strip_pkg::ring_t ring,
	input wire logic gain_led_white,
	input wire logic vol_led_red,
	input wire logic overload_indicator,
	input wire strip_pkg::chan_set_t active,
	input wire logic listening
);
	import strip_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Cycles spent listening, cleared outside
	int unsigned listen_cnt;
	// ==========================================
	// Helper counter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			listen_cnt <= 0;
		end else if (listening) begin
			listen_cnt <= listen_cnt + 1;
		end else begin
			listen_cnt <= 0;
		end
	end
	// Clip stable long enough to pass the synchroniser
	sequence clip_held;
		clip_pin [*4];
	endsequence
	// Rotation in settled listening while the proposal holds still; gain follows it a cycle late
	sequence rot_in_listen;
		listening && $past(listening) && (knob_cw || knob_ccw) && $stable(auto_gain_level);
	endsequence
	// ==========================================
	// Assertions
	AST_ONE_CHAN: assert property ($past(rst_n) |-> $onehot(chan_led))
		else $error("channel indicator not one-hot");
	AST_BTN_REFUSED: assert property (listening && (|chan_btn) |=> $stable(chan_led) [*2])
		else $error("channel changed while listening");
	AST_LISTEN_WHITE: assert property (listening && $past(listening) |-> gain_led_white)
		else $error("gain indicator dark while listening");
	AST_MUTE_RED: assert property ($rose(active.mute) |-> ##[0:2] vol_led_red)
		else $error("mute without red volume indicator");
	AST_ROT_IGNORED: assert property (rot_in_listen |=> (!listening || $stable(active.gain)))
		else $error("rotation moved gain while listening");
	AST_RING_FILL: assert property (((ring.green & (ring.green + 9'h001)) == 9'h000)
		&& ((ring.white & (ring.white + 9'h001)) == 9'h000))
		else $error("ring not filled from the left");
	AST_CLIP_RED: assert property (ring.red9 |-> !ring.green[8] && !ring.white[8])
		else $error("ninth LED lit in two colours");
	AST_OVERLOAD: assert property (clip_held |-> overload_indicator)
		else $error("clip not shown");
	AST_LISTEN_LEN: assert property ($fell(listening)
		|-> (listen_cnt >= LISTEN_CYC - 2) && (listen_cnt <= LISTEN_CYC + 2))
		else $error("listening period wrong length");
	AST_HOLD_ENTRY: assert property ($rose(listening) |-> $past(knob_press, 3) && $past(knob_press, 8))
		else $error("listening without a held knob");
endmodule : strip_ctrl_chk
bind strip_ctrl strip_ctrl_chk #(.LISTEN_CYC(LISTEN_CYC)) i_strip_ctrl_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.chan_btn(chan_btn), .knob_press(knob_press), .knob_cw(knob_cw), .knob_ccw(knob_ccw),
	.auto_gain_level(auto_gain_level),
	.clip_pin(clip_pin), .chan_led(chan_led), .ring(ring), .gain_led_white(gain_led_white),
	.vol_led_red(vol_led_red), .overload_indicator(overload_indicator), .active(active), .listening(listening));

// ==== panel_operator.sv ====
// ==========================================
// Operator model: presses the level knob and feeds the clip contact.
// Assumes the bench raises go for one cycle per press.
`timescale 1ns/1ps
module panel_operator (
	// Clock
	input wire logic ref_clk,
	// Requests from the bench
	input wire logic go,
	input wire logic [15:0] press_len,
	input wire logic clip_req,
	// Panel contacts
	output logic knob_press,
	output logic clip_pin,
	output logic busy
);
	int unsigned left = 0; // Cycles of press remaining
	logic g = 1'b0; // Request seen at the edge
	initial knob_press = 1'b0;
	initial clip_pin = 1'b0;
	// Press held for the full count; updates 1 ns after the edge, ahead of the bench drive point, to avoid races
	always @(posedge ref_clk) begin
		g = go;
		#1;
		clip_pin = clip_req;
		if (g && !knob_press) begin
			knob_press = 1'b1;
			left = press_len;
		end else if (left > 1) begin
			left = left - 1;
		end else begin
			knob_press = 1'b0;
		end
	end
	assign busy = knob_press;
endmodule : panel_operator

// ==== test_strip_ctrl.sv ====
// ==========================================
// Self-checking bench for strip_ctrl with short timing parameters.
// Assumes panel_operator and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "strip_map.svh"
module test_strip_ctrl;
	import strip_pkg::*;
	localparam int IDLE = 60, HOLD = 40, LISTEN = 50, DTAP = 20, SHOW = 20, SLOW = 30, FAST = 30;
	typedef struct {int sel; logic [31:0] exp;} note_t;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [`NUM_CH-1:0] chan_btn = '0;
	logic knob_cw = 1'b0;
	logic knob_ccw = 1'b0;
	logic edit_params_wr = 1'b0;
	logic go = 1'b0;
	logic clip_req = 1'b0;
	logic [7:0] edit_params = 8'h00;
	logic [3:0] auto_gain_level = 4'h0;
	logic [15:0] press_len = 16'h0004;
	logic knob_press, clip_pin, busy;
	logic [`NUM_CH-1:0] chan_led;
	ring_t ring;
	chan_set_t active;
	logic gain_led_white, vol_led_green, vol_led_red, overload_indicator, listening;
	int n_mismatch = 0;
	int checks_done = 0;
	int seed = 32'hbe92;
	int k;
	logic [7:0] p;
	note_t notes[$]; // Expected results, oldest first
	event look;
	always #12.5 ref_clk = ~ref_clk;
	// ==========================================
	// Instances
	strip_ctrl #(.GAIN_IDLE_CYC(IDLE), .HOLD_CYC(HOLD), .LISTEN_CYC(LISTEN), .DTAP_CYC(DTAP),
		.SHOW_CYC(SHOW), .SLOW_FLASH_CYC(SLOW), .FAST_FLASH_CYC(FAST)) i_strip_ctrl (.ref_clk(ref_clk),
		.rst_n(rst_n), .chan_btn(chan_btn), .knob_press(knob_press), .knob_cw(knob_cw), .knob_ccw(knob_ccw),
		.edit_params(edit_params), .edit_params_wr(edit_params_wr), .auto_gain_level(auto_gain_level),
		.clip_pin(clip_pin), .chan_led(chan_led), .ring(ring), .gain_led_white(gain_led_white),
		.vol_led_green(vol_led_green), .vol_led_red(vol_led_red), .overload_indicator(overload_indicator),
		.active(active), .listening(listening));
	panel_operator i_panel_operator (.ref_clk(ref_clk), .go(go), .press_len(press_len), .clip_req(clip_req),
		.knob_press(knob_press), .clip_pin(clip_pin), .busy(busy));
	// ==========================================
	// Helpers
	// Observed field by selector
	function automatic logic [31:0] obs(input int sel);
		case (sel)
			0: return 32'(chan_led);
			1: return 32'(active.volume);
			2: return 32'(active.gain);
			3: return 32'(active.mute);
			4: return 32'(active.auto_set);
			5: return 32'(active.eq_comp_fx);
			6: return 32'(ring.green);
			7: return 32'(ring.white);
			8: return 32'(ring.red9);
			9: return 32'({listening, gain_led_white, vol_led_green, vol_led_red, overload_indicator});
			default: return 32'({listening, gain_led_white});
		endcase
	endfunction : obs
	// LEDs lit up to and including a position
	function automatic logic [31:0] therm(input int n);
		return (32'h1 << (n + 1)) - 32'h1;
	endfunction : therm
	// Land just after an edge, the drive point
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : step
	task automatic chk(input int sel, input logic [31:0] exp);
		notes.push_back('{sel, exp});
		-> look;
	endtask : chk
	task automatic press(input int len);
		press_len = 16'(len);
		go = 1'b1;
		step(1);
		go = 1'b0;
		for (int i = 0; i < 5000 && busy === 1'b1; i++) step(1);
	endtask : press
	task automatic press_btn(input int c);
		chan_btn = 6'(1 << c);
		step(1);
		chan_btn = '0;
		step(4);
	endtask : press_btn
	task automatic rot(input logic dir, input int n);
		for (int i = 0; i < n; i++) begin
			knob_cw = dir;
			knob_ccw = !dir;
			step(1);
			knob_cw = 1'b0;
			knob_ccw = 1'b0;
			step(3);
		end
	endtask : rot
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	// ==========================================
	// Monitor: compares each note against the outputs
	always @(look) begin
		note_t n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			checks_done++;
			if (obs(n.sel) !== n.exp) begin
				n_mismatch++;
				$display("unexpected at %0t: got %h expected %h", $time, obs(n.sel), n.exp);
			end
		end
	end
	// Watchdog at 20000 cycles, well beyond the expected run of under a thousand cycles
	initial begin
		#(25 * 20000);
		n_mismatch++;
		results();
	end
	// ==========================================
	// Main sequence
	initial begin
		step(6);
		rst_n = 1'b1;
		step(3);
		chk(0, 32'h1);
		chk(1, 32'h5);
		chk(2, 32'h5);
		chk(6, therm(5));
		chk(9, 32'h04);
		$display("test reset done");
		k = 1 + (($random(seed) & 32'h7fffffff) % 5);
		p = 8'($random(seed));
		press_btn(k);
		chk(0, 32'h1 << k);
		edit_params = p;
		edit_params_wr = 1'b1;
		step(1);
		edit_params_wr = 1'b0;
		rot(1'b1, 4);
		chk(1, 32'h8);
		chk(6, therm(8));
		press_btn(0);
		chk(1, 32'h5);
		press_btn(k);
		chk(1, 32'h8);
		chk(5, 32'(p));
		$display("test channel recall done");
		clip_req = 1'b1;
		step(6);
		chk(8, 32'h1);
		chk(6, therm(7));
		chk(9, 32'h05);
		clip_req = 1'b0;
		step(6);
		chk(8, 32'h0);
		$display("test clip done");
		press(4);
		step(DTAP + 8);
		chk(9, 32'h08);
		chk(7, therm(5));
		chk(6, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rot(1'b1, 1);
			step(IDLE - 20);
		end
		chk(9, 32'h08);
		chk(7, therm(8));
		step(IDLE + 10);
		chk(9, 32'h04);
		press(4);
		step(DTAP + 8);
		chk(9, 32'h08);
		press(4);
		step(DTAP + 8);
		chk(9, 32'h04);
		$display("test gain mode done");
		press(4);
		step(5);
		press(4);
		step(DTAP + 8);
		chk(3, 32'h1);
		chk(9, 32'h02);
		press(4);
		step(DTAP + 8);
		chk(3, 32'h0);
		chk(9, 32'h04);
		$display("test mute done");
		for (int i = 0; i < 2; i++) begin
			auto_gain_level = (i == 0) ? 4'h3 : 4'h7;
			press_len = 16'(HOLD + 10);
			go = 1'b1;
			step(1);
			go = 1'b0;
			step(HOLD + 6);
			chk(10, 32'h3);
			press_btn(0);
			chk(0, 32'h1 << k);
			rot(1'b0, 2);
			// Land inside the show phase, then inside the slow flash
			step(LISTEN - 10);
			chk(7, therm(int'(auto_gain_level)));
			step(SHOW + 2);
			chk(7, 32'h1ff);
			step(SLOW + FAST + 18);
			chk(9, 32'h04);
			chk(2, 32'(auto_gain_level));
			chk(4, 32'h1);
		end
		press(4);
		step(DTAP + 8);
		rot(1'b0, 1);
		chk(2, 32'h6);
		chk(4, 32'h0);
		step(IDLE + 10);
		$display("test auto-gain done");
		step(2);
		results();
	end
endmodule : test_strip_ctrl
